// File: bench/csf_codec_properties.sv
// assertion checker on the ports of the codec-side sample sync block
`timescale 1ns/1ps
module csf_codec_properties (
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	// link
	input wire logic        sclk_i,
	input wire logic        serial_rx_line_o,
	// host port
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// converters
	input wire logic [11:0] aud_dac_o,
	input wire logic [13:0] tel_dac_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence ctrl_wr_rd;
		wr_i && addr_i == csf_pkg::HR_CTRL ##1 rd_i && addr_i == csf_pkg::HR_CTRL;
	endsequence
	sequence dac_rd_wr_rd;
		rd_i && addr_i == csf_pkg::HR_DAC_AUD ##1 wr_i && addr_i == csf_pkg::HR_DAC_AUD
			##1 rd_i && addr_i == csf_pkg::HR_DAC_AUD;
	endsequence
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data not idle");
	unmapped_zero_a: assert property (rd_i && addr_i == 8'h18 |=> rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property (ctrl_wr_rd |=> rdata_o[1:0] == $past(wdata_i[1:0], 2))
		else $error("control readback differs");
	dac_ro_a: assert property (dac_rd_wr_rd |=> rdata_o == $past(rdata_o, 2))
		else $error("read-only register written");
	// return data only moves after a bit clock rise, or when clearing the enable bit forces it low
	rx_edge_a: assert property ($changed(serial_rx_line_o) |-> $past(sclk_i, 2) || $past(sclk_i, 3))
		else $error("return line moved off the rise");
	dac_reset_a: assert property ($fell(reset_i) |-> aud_dac_o == 12'h000 && tel_dac_o == 14'h0000)
		else $error("converter output not cleared");
	aud_dac_a: assert property (rd_i && addr_i == csf_pkg::HR_DAC_AUD |=> rdata_o[15:4] == $past(aud_dac_o))
		else $error("audio output and register differ");
	tel_dac_a: assert property (rd_i && addr_i == csf_pkg::HR_DAC_TEL |=> rdata_o[15:2] == $past(tel_dac_o))
		else $error("telecom output and register differ");
endmodule : csf_codec_properties

// File: bench/csf_unit_model.sv
// behavioural codec port unit: bit clock, frame pulse and 64-bit shifter
`timescale 1ns/1ps
module csf_unit_model (
	// control
	input  wire logic        run_i,
	input  wire logic [63:0] tx_word_i,
	// link
	input  wire logic        serial_rx_line_i,
	output logic             sclk_o,
	output logic             frame_sync_pulse_o,
	output logic             serial_tx_line_o,
	// frame results
	output logic [63:0]      rx_word_o,
	output int               frames_o
);
	logic [63:0] sh = 64'h0;
	logic [63:0] cap = 64'h0;
	int          idx = 126;
	initial begin
		sclk_o = 1'b0;
		frame_sync_pulse_o = 1'b0;
		serial_tx_line_o = 1'b0;
		rx_word_o = 64'h0;
		frames_o = 0;
	end
	// clock stands still while stopped; 320 ns per bit otherwise
	always begin
		#160;
		if (run_i) begin
			if (idx < 64)
				cap[63 - idx] = serial_rx_line_i;
			idx = (idx + 1) % 128;
			if (idx == 64) begin
				rx_word_o = cap;
				frames_o++;
			end
			if (idx == 127)
				sh = tx_word_i;
			frame_sync_pulse_o = (idx == 127);
			// line pulled low outside subframe 0
			serial_tx_line_o = (idx < 64) ? sh[63 - idx] : 1'b0;
			sclk_o = 1'b1;
			#160;
			sclk_o = 1'b0;
		end
	end
endmodule : csf_unit_model

// File: bench/tb_csf_codec_top.sv
// self-checking bench for the codec-side sample sync block
`timescale 1ns/1ps
module tb_csf_codec_top;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        run = 1'b0;
	logic        sclk, fsync, txl, rxl, rd_q;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o, rv;
	logic [11:0] aud_dac_o;
	logic [13:0] tel_dac_o;
	logic [63:0] txw = 64'h0;
	logic [63:0] rxw;
	logic [15:0] sm[2];
	logic [3:0]  last_ca;
	int          pend[2];
	int          frames, mismatches, n_compared, persist;
	int          creg[16], div[2], cnt[2], conv[2], run_p[2], vld[2], dac[2], adc[2];
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		rd_q <= rd_i;
		if (rd_q)
			rv <= rdata_o;
	end
	csf_unit_model csf_unit_model_inst (.run_i(run), .tx_word_i(txw), .serial_rx_line_i(rxl),
		.sclk_o(sclk), .frame_sync_pulse_o(fsync), .serial_tx_line_o(txl), .rx_word_o(rxw),
		.frames_o(frames));
	csf_codec_top csf_codec_top_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
		.sclk_i(sclk), .frame_sync_pulse_i(fsync), .serial_tx_line_i(txl),
		.serial_rx_line_o(rxl), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .aud_dac_o(aud_dac_o), .tel_dac_o(tel_dac_o));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
	endtask : bus
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
		bus(1'b0, 1'b0, a, 32'h0000_0000);
		@(posedge clk_sys_i);
		#1 chk(nm, e, rv);
	endtask : rdchk
	// one frame: settle the pulse before it, then check the returned word
	task automatic frame(input logic [3:0] ca, input logic [15:0] cd);
		logic [15:0] s[2];
		int p;
		int on;
		s[0] = 16'($urandom) & 16'hfff0;
		s[1] = 16'($urandom) & 16'hfffc;
		txw = {s[0], 1'b0, ca, 1'b1, s[1], 1'b0, 9'h000, cd};
		for (p = 0; p < 2; p++) begin
			on = creg[p ? 4 : 8];
			// a disable stops the counter at the pulse, before its last tick
			if (on[15:14] == 0)
				run_p[p] = 0;
			if (run_p[p] != 0)
				cnt[p] -= 4;
			// a sample taken at a pulse rides in the frame after it
			vld[p] = (persist & vld[p] | pend[p]) & on[15];
			pend[p] = 0;
			if (run_p[p] != 0 && cnt[p] == 0) begin
				cnt[p] = div[p];
				conv[p]++;
				if (on[15])
					pend[p] = 1;
				if (on[14])
					dac[p] = sm[p];
			end
			if (on[15:14] != 0 && run_p[p] == 0) begin
				run_p[p] = 1;
				div[p] = (p ? 16 : 6) > on[6:0] ? (p ? 16 : 6) : on[6:0];
				cnt[p] = div[p];
			end
			sm[p] = s[p];
		end
		@(frames);
		chk("aud valid", vld[0], rxw[47]);
		chk("tel valid", vld[1], rxw[25]);
		if (vld[0] != 0)
			chk("aud sample", adc[0] << 4, rxw[63:48]);
		if (vld[1] != 0)
			chk("tel sample", adc[1] << 2, rxw[41:26]);
		// the address comes back a frame late: it arrives too late to echo
		chk("reg addr", {last_ca, 1'b0}, rxw[46:42]);
		chk("reg data", creg[ca], rxw[15:0]);
		chk("aud out", dac[0] >> 4, aud_dac_o);
		chk("tel out", dac[1] >> 2, tel_dac_o);
		creg[ca] = cd;
		last_ca = ca;
	endtask : frame
	task automatic counts;
		bus(1'b0, 1'b1, csf_pkg::HR_STATUS, 32'h0000_0000);
		bus(1'b0, 1'b0, csf_pkg::HR_STATUS, 32'h0000_0000);
		@(posedge clk_sys_i);
		#1 chk("aud count", conv[0], rv[23:16]);
		chk("tel count", conv[1], rv[31:24]);
		rdchk("aud dac reg", csf_pkg::HR_DAC_AUD, dac[0]);
		rdchk("tel dac reg", csf_pkg::HR_DAC_TEL, dac[1]);
	endtask : counts
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial begin
		#3_000_000;
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(32'hde84a369));
		for (int m = 0; m < 2; m++) begin
			txw = 64'h0;
			reset_i <= 1'b1;
			repeat (12) @(posedge clk_sys_i);
			reset_i <= 1'b0;
			foreach (creg[i])
				creg[i] = 0;
			for (int p = 0; p < 2; p++) begin
				{run_p[p], vld[p], dac[p], conv[p], sm[p]} = '0;
				pend[p] = 0;
				adc[p] = $urandom % (p ? 16384 : 4096);
			end
			persist = m;
			last_ca = 4'h0;
			rdchk("ctrl reset", csf_pkg::HR_CTRL, 32'h0000_0000);
			rdchk("unmapped", 8'h18, 32'h0000_0000);
			bus(1'b0, 1'b1, csf_pkg::HR_DAC_AUD, 32'h0000_0000);
			bus(1'b1, 1'b0, csf_pkg::HR_DAC_AUD, 32'hffff_ffff);
			rdchk("dac read-only", csf_pkg::HR_DAC_AUD, 32'h0000_0000);
			bus(1'b1, 1'b0, csf_pkg::HR_ADC_AUD, adc[0]);
			bus(1'b1, 1'b0, csf_pkg::HR_ADC_TEL, adc[1]);
			bus(1'b1, 1'b0, csf_pkg::HR_CTRL, {30'h0, m[0], 1'b1});
			rdchk("ctrl", csf_pkg::HR_CTRL, {30'h0, m[0], 1'b1});
			run = 1'b1;
			@(frames);
			frame(4'h8, 16'hc00c);
			if (m == 0)
				frame(4'h4, 16'hc008);
			repeat (m ? 8 : 13) frame(4'h1, 16'($urandom));
			counts();
			frame(4'h8, 16'h000c);
			repeat (4) frame(4'h1, 16'($urandom));
			counts();
		end
		final_report();
	end
endmodule : tb_csf_codec_top
bind csf_codec_top csf_codec_properties csf_codec_properties_inst (.clk_sys_i(clk_sys_i),
	.reset_i(reset_i), .sclk_i(sclk_i), .serial_rx_line_o(serial_rx_line_o), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .aud_dac_o(aud_dac_o),
	.tel_dac_o(tel_dac_o));

// File: core/csf_codec_top.sv
// codec-side end of the sample-synchronised serial link
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module csf_codec_top (
	// clock and control
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	// link from the codec port unit
	input  wire logic        sclk_i,
	input  wire logic        frame_sync_pulse_i,
	input  wire logic        serial_tx_line_i,
	output logic             serial_rx_line_o,
	// host register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	// converter outputs
	output logic [11:0]      aud_dac_o,
	output logic [13:0]      tel_dac_o
);
	typedef struct packed {
		csf_pkg::csf_link_state_t st;
		logic [6:0]               bitcnt;
		logic [63:0]              txw;
		logic [63:0]              rxs;
		logic                     tx;
		logic [3:0]               cad;
		logic                     crw;
		logic [15:0][15:0]        creg;
		logic [1:0]               ctrl;
		logic [1:0][15:0]         adc;
		logic [1:0][15:0]         smp;
		logic [1:0][15:0]         rxf;
		logic [1:0][15:0]         dac;
		logic [1:0]               fresh;
		logic [1:0]               rel;
		logic [1:0][7:0]          cnv;
		logic [31:0]              rdata;
	} csf_top_state_t;

	csf_top_state_t r_reg;
	csf_top_state_t r_next;

	csf_link_if link ();

	logic       frame;
	logic       tick;
	logic [1:0] path_en;
	logic [1:0] running;
	logic [1:0] zero;
	logic [6:0] modulus [2];

	// codec register address of a path
	function automatic logic [3:0] path_creg(input int p);
		return (p == 0) ? csf_pkg::CREG_AUD : csf_pkg::CREG_TEL;
	endfunction : path_creg

	// out-of-range divisors are raised to the path minimum
	function automatic logic [6:0] clamp_div(input logic [15:0] cr, input int p);
		logic [6:0] d;
		logic [6:0] lo;
		d = cr[csf_pkg::CB_DIV_LSB +: 7];
		lo = (p == 0) ? csf_pkg::DIV_MIN_AUD : csf_pkg::DIV_MIN_TEL;
		return (d < lo) ? lo : d;
	endfunction : clamp_div

	// bit position of a path's sample field
	function automatic int field_lsb(input int p);
		return (p == 0) ? csf_pkg::F_AUD_LSB : csf_pkg::F_TEL_LSB;
	endfunction : field_lsb

	function automatic int valid_bit(input int p);
		return (p == 0) ? csf_pkg::F_AUD_VALID : csf_pkg::F_TEL_VALID;
	endfunction : valid_bit

	csf_link_sampler u_sampler (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.sclk_i    (sclk_i),
		.fsync_i   (frame_sync_pulse_i),
		.rx_i      (serial_tx_line_i),
		.link      (link.src)
	);

	// the fixed divide-by-32 stage: one tick per 32 bit clocks
	assign frame = link.sclk_fall & link.fsync & r_reg.ctrl[csf_pkg::CTRL_EN];
	assign tick = link.sclk_fall & (r_reg.st != csf_pkg::LS_IDLE)
		& (r_reg.bitcnt[4:0] == csf_pkg::SLOT_LAST);

	for (genvar p = 0; p < 2; p++) begin : g_path
		assign path_en[p] = r_reg.creg[path_creg(p)][csf_pkg::CB_IN_EN]
			| r_reg.creg[path_creg(p)][csf_pkg::CB_OUT_EN];
		assign modulus[p] = clamp_div(r_reg.creg[path_creg(p)], p);

		csf_rate_counter u_cnt (
			.clk_sys_i (clk_sys_i),
			.reset_i   (reset_i),
			.ce_i      (ce_i),
			.frame_i   (frame),
			.tick_i    (tick),
			.enable_i  (path_en[p]),
			.modulus_i (modulus[p]),
			.running_o (running[p]),
			.zero_o    (zero[p])
		);
	end

	// the address sits just above the r/w bit in the low end of the shifter
	localparam int F_ADDR_REL = csf_pkg::F_ADDR_LSB - csf_pkg::F_RW;

	always_comb begin
		logic [63:0] rx_new;
		logic [3:0]  a;
		rx_new = {r_reg.rxs[62:0], link.rx};
		a = rx_new[F_ADDR_REL +: 4];
		r_next = r_reg;
		r_next.rdata = 32'h0000_0000;

		// link framing
		if (frame) begin
			r_next.st = csf_pkg::LS_SUB0;
			r_next.bitcnt = 7'h00;
			r_next.txw = 64'h0000_0000_0000_0000;
			for (int p = 0; p < 2; p++) begin
				r_next.txw[field_lsb(p) +: 16] = r_reg.smp[p];
				r_next.txw[valid_bit(p)] = r_reg.ctrl[csf_pkg::CTRL_PERSIST]
					? r_reg.rel[p] : r_reg.fresh[p];
				r_next.fresh[p] = 1'b0;
			end
			r_next.txw[csf_pkg::F_ADDR_LSB +: 4] = r_reg.cad;
		end else if (link.sclk_rise) begin
			// the unit samples just before its next rising edge, so drive on the rise
			if (r_reg.st == csf_pkg::LS_SUB0) begin
				r_next.tx = r_reg.txw[~r_reg.bitcnt[5:0]];
			end else begin
				r_next.tx = 1'b0;
			end
		end else if (link.sclk_fall && r_reg.st != csf_pkg::LS_IDLE) begin
			r_next.rxs = rx_new;
			r_next.bitcnt = r_reg.bitcnt + 7'h01;
			if (r_reg.st == csf_pkg::LS_SUB0 && r_reg.bitcnt == csf_pkg::IDX_ADDR_DONE) begin
				// the read data field goes out last, so it can still be filled
				r_next.cad = a;
				r_next.crw = rx_new[0];
				r_next.txw[csf_pkg::F_REG_LSB +: 16] = r_reg.creg[a];
			end
			if (r_reg.st == csf_pkg::LS_SUB0 && r_reg.bitcnt == csf_pkg::IDX_SUB0_LAST) begin
				r_next.st = csf_pkg::LS_SUB1;
				if (r_reg.crw) begin
					r_next.creg[r_reg.cad] = rx_new[csf_pkg::F_REG_LSB +: 16];
				end
				for (int p = 0; p < 2; p++) begin
					r_next.rxf[p] = rx_new[field_lsb(p) +: 16];
				end
			end
			if (r_reg.st == csf_pkg::LS_SUB1 && r_reg.bitcnt == csf_pkg::IDX_FRAME_LAST) begin
				// no frame pulse arrived: wait for the next one
				r_next.st = csf_pkg::LS_IDLE;
			end
		end

		// conversions paced by the sample-rate counters
		for (int p = 0; p < 2; p++) begin
			if (!r_reg.creg[path_creg(p)][csf_pkg::CB_IN_EN]) begin
				r_next.rel[p] = 1'b0;
				r_next.fresh[p] = 1'b0;
			end else if (zero[p]) begin
				r_next.smp[p] = r_reg.adc[p];
				r_next.fresh[p] = 1'b1;
				r_next.rel[p] = 1'b1;
				r_next.cnv[p] = r_reg.cnv[p] + 8'h01;
			end
			if (zero[p] && r_reg.creg[path_creg(p)][csf_pkg::CB_OUT_EN]) begin
				// unchanged frames simply convert the same value again
				r_next.dac[p] = r_reg.rxf[p];
			end
		end

		if (!r_reg.ctrl[csf_pkg::CTRL_EN]) begin
			r_next.st = csf_pkg::LS_IDLE;
			r_next.tx = 1'b0;
		end

		// host register port
		if (wr_i) begin
			if (addr_i == csf_pkg::HR_CTRL) begin
				r_next.ctrl = wdata_i[1:0];
			end else if (addr_i == csf_pkg::HR_ADC_AUD) begin
				r_next.adc[0] = {wdata_i[csf_pkg::AUD_BITS-1:0], 4'h0};
			end else if (addr_i == csf_pkg::HR_ADC_TEL) begin
				r_next.adc[1] = {wdata_i[csf_pkg::TEL_BITS-1:0], 2'h0};
			end
		end
		if (rd_i) begin
			if (addr_i == csf_pkg::HR_CTRL) begin
				r_next.rdata = {30'h0000_0000, r_reg.ctrl};
			end else if (addr_i == csf_pkg::HR_ADC_AUD) begin
				r_next.rdata = {16'h0000, r_reg.adc[0]};
			end else if (addr_i == csf_pkg::HR_ADC_TEL) begin
				r_next.rdata = {16'h0000, r_reg.adc[1]};
			end else if (addr_i == csf_pkg::HR_DAC_AUD) begin
				r_next.rdata = {16'h0000, r_reg.dac[0]};
			end else if (addr_i == csf_pkg::HR_DAC_TEL) begin
				r_next.rdata = {16'h0000, r_reg.dac[1]};
			end else if (addr_i == csf_pkg::HR_STATUS) begin
				r_next.rdata = {r_reg.cnv[1], r_reg.cnv[0], 10'h000,
					r_reg.st, path_en, running};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r_reg <= '0;
			r_reg.st <= csf_pkg::LS_IDLE;
			r_reg.ctrl <= csf_pkg::CTRL_RST;
			r_reg.creg <= {16{csf_pkg::CREG_RST}};
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	assign serial_rx_line_o = r_reg.tx;
	assign rdata_o = r_reg.rdata;
	assign aud_dac_o = r_reg.dac[0][15 -: csf_pkg::AUD_BITS];
	assign tel_dac_o = r_reg.dac[1][15 -: csf_pkg::TEL_BITS];
endmodule : csf_codec_top

// File: core/csf_link_if.sv
// carrier for synchronised link events between sampler and core
`timescale 1ns/1ps
interface csf_link_if;
	logic sclk_rise;
	logic sclk_fall;
	logic fsync;
	logic rx;
	modport src (output sclk_rise, output sclk_fall, output fsync, output rx);
	modport dst (input sclk_rise, input sclk_fall, input fsync, input rx);
endinterface : csf_link_if

// File: core/csf_link_sampler.sv
// two-flop synchroniser and bit clock edge finder for the link pins
`timescale 1ns/1ps
module csf_link_sampler (
	// clock and control
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	input  wire logic ce_i,
	// pins
	input  wire logic sclk_i,
	input  wire logic fsync_i,
	input  wire logic rx_i,
	// events
	csf_link_if.src   link
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic       sclk_prev;
	} csf_smp_state_t;

	csf_smp_state_t r_reg;
	csf_smp_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = {rx_i, fsync_i, sclk_i};
		r_next.s2 = r_reg.s1;
		r_next.sclk_prev = r_reg.s2[0];
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r_reg <= '0;
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	assign link.sclk_rise = ce_i & r_reg.s2[0] & ~r_reg.sclk_prev;
	assign link.sclk_fall = ce_i & ~r_reg.s2[0] & r_reg.sclk_prev;
	assign link.fsync = r_reg.s2[1];
	assign link.rx = r_reg.s2[2];
endmodule : csf_link_sampler

// File: core/csf_pkg.sv
// shared constants and types for the codec-side sample sync block
package csf_pkg;
	// frame geometry
	localparam logic [6:0] IDX_ADDR_DONE = 7'h15;
	localparam logic [6:0] IDX_SUB0_LAST = 7'h3F;
	localparam logic [6:0] IDX_FRAME_LAST = 7'h7F;
	localparam logic [4:0] SLOT_LAST = 5'h1F;
	// fields of the 64-bit subframe 0 word, same layout both ways
	localparam int F_AUD_LSB = 48;
	localparam int F_AUD_VALID = 47;
	localparam int F_ADDR_LSB = 43;
	localparam int F_RW = 42;
	localparam int F_TEL_LSB = 26;
	localparam int F_TEL_VALID = 25;
	localparam int F_REG_LSB = 0;
	// codec control registers that carry the path settings
	localparam logic [3:0] CREG_AUD = 4'h8;
	localparam logic [3:0] CREG_TEL = 4'h4;
	localparam int CB_DIV_LSB = 0;
	localparam int CB_OUT_EN = 14;
	localparam int CB_IN_EN = 15;
	localparam logic [15:0] CREG_RST = 16'h0000;
	// divisor limits
	localparam logic [6:0] DIV_MIN_AUD = 7'h06;
	localparam logic [6:0] DIV_MIN_TEL = 7'h10;
	// host register offsets
	localparam logic [7:0] HR_CTRL = 8'h00;
	localparam logic [7:0] HR_ADC_AUD = 8'h04;
	localparam logic [7:0] HR_ADC_TEL = 8'h08;
	localparam logic [7:0] HR_DAC_AUD = 8'h0C;
	localparam logic [7:0] HR_DAC_TEL = 8'h10;
	localparam logic [7:0] HR_STATUS = 8'h14;
	localparam int CTRL_EN = 0;
	localparam int CTRL_PERSIST = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int AUD_BITS = 12;
	localparam int TEL_BITS = 14;

	typedef enum logic [1:0] {
		LS_IDLE = 2'b00,
		LS_SUB0 = 2'b01,
		LS_SUB1 = 2'b11
	} csf_link_state_t;
endpackage : csf_pkg

// File: core/csf_rate_counter.sv
// sample-rate counter: ticks once per 32 bit clocks, zero pulse on wrap
`timescale 1ns/1ps
module csf_rate_counter (
	// clock and control
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	// pacing
	input  wire logic       frame_i,
	input  wire logic       tick_i,
	input  wire logic       enable_i,
	input  wire logic [6:0] modulus_i,
	// status
	output logic            running_o,
	output logic            zero_o
);
	typedef struct packed {
		logic       running;
		logic [6:0] count;
		logic       zero;
	} csf_cnt_state_t;

	csf_cnt_state_t r_reg;
	csf_cnt_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.zero = 1'b0;
		if (frame_i && !enable_i) begin
			r_next.running = 1'b0;
			r_next.count = modulus_i;
		end else if (frame_i && !r_reg.running) begin
			r_next.running = 1'b1;
			r_next.count = modulus_i;
		end else if (r_reg.running && tick_i) begin
			if (r_reg.count <= 7'h01) begin
				r_next.zero = 1'b1;
				r_next.count = modulus_i;
			end else begin
				r_next.count = r_reg.count - 7'h01;
			end
		end else if (!r_reg.running) begin
			r_next.count = modulus_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r_reg <= '0;
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	assign running_o = r_reg.running;
	assign zero_o = r_reg.zero;
endmodule : csf_rate_counter
